// [core/tpu_pkg.sv]
// How it works
// [RULE1] trap entry clears single-step mode bit
// [RULE2] breakpoint and step traps unmaskable, resumable
// [RULE3] four mailbox sets, control plus seven words
// [RULE4] bus and control memory share mailbox storage
// [RULE5] data words read back last written value
// [RULE6] control word stores like a data word
// [RULE7] bus write to control word requests trap
// [RULE8] no other mailbox access requests a trap
// [RULE9] requester waits for acknowledge before re-requesting
// [RULE10] mailbox traps precise, maskable, resumable
// [RULE11] queue after bounds check, execute in order
// [RULE12] scoreboard stalls on pending register operations; one busy bit per register clears when its first queued op completes
// [RULE13] memory-operation traps are imprecise
// [RULE14] memory error sets status word bit
// [RULE15] memory trap needs enable and no mask
// [RULE16] status word cleared only by supervisor move
// [RULE17] fixed priority reset, fault, call, break, step, maskable
// [RULE18] reset overrides all, discards pending work
// [RULE19] trap entry disables step and maskable traps
// [RULE20] halted: keep first maskable request only; a memory error and a bus control-word write in that first cycle are both kept
// [RULE21] control-word request pends until trap taken
package tpu_pkg;

    localparam int MBOX_SETS      = 4;
    localparam int MBOX_WORDS     = 8;
    localparam int MBOX_ENTRIES   = MBOX_SETS * MBOX_WORDS;
    localparam int MBOX_AW        = 5;
    localparam int WORD_W         = 32;
    localparam int MASK_SRCS      = 5;
    localparam int MEM_ERR_BITS   = 2;
    localparam int MEM_SRC_IDX    = 4;
    localparam int REG_IDX_W      = 6;
    localparam int MEM_ADDR_W     = 16;

    localparam logic [2:0] CTRL_WORD_IDX = 3'h0;

    // control register selectors for the supervisor move port
    localparam logic [1:0] CSR_SEL_PSW  = 2'h0;
    localparam logic [1:0] CSR_SEL_MASK = 2'h1;
    localparam logic [1:0] CSR_SEL_MSTS = 2'h2;
    localparam logic [1:0] CSR_SEL_TREQ = 2'h3;

    localparam int PSW_STEP_BIT = 0;
    localparam int PSW_IEN_BIT  = 1;

    localparam logic [MASK_SRCS-1:0] MASK_RESET = 5'h1f;

    typedef enum logic [2:0] {
        TPU_CAUSE_RESET = 3'b000,
        TPU_CAUSE_FAULT = 3'b001,
        TPU_CAUSE_CALL  = 3'b010,
        TPU_CAUSE_BREAK = 3'b011,
        TPU_CAUSE_STEP  = 3'b100,
        TPU_CAUSE_MASK  = 3'b101
    } tpu_cause_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [MBOX_AW-1:0] addr;
        logic [WORD_W-1:0]  wdata;
    } tpu_mbox_req_t;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic              supervisor;
        logic [1:0]        sel;
        logic [WORD_W-1:0] wdata;
    } tpu_csr_req_t;

    typedef struct packed {
        logic                  load;
        logic [REG_IDX_W-1:0]  regIdx;
        logic [MEM_ADDR_W-1:0] addr;
    } tpu_mop_t;

endpackage : tpu_pkg

// [core/tpu_trap_unit.sv]
`timescale 1ns/1ps

module tpu_trap_unit
    import tpu_pkg::*;
#(
    parameter int MOP_DEPTH  = 4,
    parameter int MOP_PTR_W  = 2
) (
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // bus-side mailbox port
    input  wire tpu_mbox_req_t       vmeReq,
    output logic                     vmeAck,
    output logic [WORD_W-1:0]        vmeRdata,
    // control memory mailbox port
    input  wire tpu_mbox_req_t       smemReq,
    output logic                     smemAck,
    output logic [WORD_W-1:0]        smemRdata,
    // supervisor control register move port
    input  wire tpu_csr_req_t        csrReq,
    output logic [WORD_W-1:0]        csrRdata,
    // trap sources from the core
    input  wire logic                resetReq,
    input  wire logic                faultReq,
    input  wire logic                callReq,
    input  wire logic                breakReq,
    input  wire logic                stepReq,
    input  wire logic                halted,
    input  wire logic                pswRestore,
    input  wire logic [1:0]          pswRestoreVal,
    // trap sequencer handshake
    output logic                     trapValid,
    output tpu_cause_t               trapCause,
    output logic [2:0]               trapSource,
    output logic                     trapPrecise,
    output logic                     trapResumable,
    input  wire logic                trapAccept,
    output logic                     stepEnable,
    output logic                     intEnable,
    // memory-operation issue side
    input  wire logic                mopValid,
    input  wire logic                mopBoundsDone,
    input  wire tpu_mop_t            mopIn,
    output logic                     mopReady,
    input  wire logic [REG_IDX_W-1:0] useRegA,
    input  wire logic [REG_IDX_W-1:0] useRegB,
    output logic                     elemStall,
    // element memory side
    output logic                     memReqValid,
    output tpu_mop_t                 memReq,
    input  wire logic                memReqReady,
    input  wire logic                memRespValid,
    input  wire logic [MEM_ERR_BITS-1:0] memRespErr
);

    // ************************************************************
    // mailbox table
    // ************************************************************
    logic [WORD_W-1:0]    mbox_reg [MBOX_ENTRIES]; // RULE3
    logic                 vmeAck_reg;
    logic                 smemAck_reg;
    logic [WORD_W-1:0]    vmeRdata_reg;
    logic [WORD_W-1:0]    smemRdata_reg;

    wire vmeWr  = vmeReq.valid & vmeReq.write;
    wire smemWr = smemReq.valid & smemReq.write;
    wire vmeCtrlWr = vmeWr & (vmeReq.addr[2:0] == CTRL_WORD_IDX); // RULE7 RULE8
    wire [1:0] vmeSet = vmeReq.addr[MBOX_AW-1:3];

    genvar gi;
    generate
        for (gi = 0; gi < MBOX_ENTRIES; gi++) begin : g_mbox
            // same storage from both sides; bus wins a same-word collision
            wire hitV = vmeWr & (vmeReq.addr == MBOX_AW'(gi));
            wire hitC = smemWr & (smemReq.addr == MBOX_AW'(gi));
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    mbox_reg[gi] <= '0;
                end else if (hitV) begin
                    mbox_reg[gi] <= vmeReq.wdata; // RULE4 RULE5 RULE6
                end else if (hitC) begin
                    mbox_reg[gi] <= smemReq.wdata; // RULE4 RULE5 RULE6
                end
            end
        end
    endgenerate

    // reads see the stored word; a read beside a write returns the old value
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vmeAck_reg    <= 1'b0;
            smemAck_reg   <= 1'b0;
            vmeRdata_reg  <= '0;
            smemRdata_reg <= '0;
        end else begin
            vmeAck_reg    <= vmeReq.valid;
            smemAck_reg   <= smemReq.valid;
            vmeRdata_reg  <= mbox_reg[vmeReq.addr]; // RULE5
            smemRdata_reg <= mbox_reg[smemReq.addr]; // RULE5
        end
    end

    assign vmeAck    = vmeAck_reg;
    assign smemAck   = smemAck_reg;
    assign vmeRdata  = vmeRdata_reg;
    assign smemRdata = smemRdata_reg;

    // ************************************************************
    // memory-operation queue and scoreboard
    // ************************************************************
    tpu_mop_t                 mopq_reg [MOP_DEPTH];
    logic [MOP_PTR_W-1:0]     wrPtr_reg;
    logic [MOP_PTR_W-1:0]     rdPtr_reg;
    logic [MOP_PTR_W:0]       count_reg;
    logic                     sent_reg;
    logic [(1<<REG_IDX_W)-1:0] busy_reg;

    wire mopFull  = (count_reg == (MOP_PTR_W+1)'(MOP_DEPTH));
    wire mopEmpty = (count_reg == '0);
    assign mopReady = ~mopFull & ~resetReq;
    // only requests whose bounds checks are finished may enter
    wire mopPush  = mopValid & mopBoundsDone & mopReady; // RULE11
    wire mopPop   = memRespValid & ~mopEmpty & sent_reg;
    wire [MOP_PTR_W:0] countNext = count_reg + (MOP_PTR_W+1)'(mopPush)
                                 - (MOP_PTR_W+1)'(mopPop);

    always_ff @(posedge sys_clk) begin
        if (mopPush) begin
            mopq_reg[wrPtr_reg] <= mopIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || resetReq) begin
            wrPtr_reg <= '0; // RULE18
            rdPtr_reg <= '0;
            count_reg <= '0;
            sent_reg  <= 1'b0;
        end else begin
            wrPtr_reg <= wrPtr_reg + MOP_PTR_W'(mopPush);
            rdPtr_reg <= rdPtr_reg + MOP_PTR_W'(mopPop); // RULE11
            count_reg <= countNext;
            sent_reg  <= mopPop ? 1'b0 : (sent_reg | (memReqValid & memReqReady));
        end
    end

    // one operation in flight, taken strictly from the head
    assign memReqValid = ~mopEmpty & ~sent_reg; // RULE11
    assign memReq      = mopq_reg[rdPtr_reg];

    generate
        for (gi = 0; gi < (1 << REG_IDX_W); gi++) begin : g_sb
            wire setB = mopPush & (mopIn.regIdx == REG_IDX_W'(gi));
            wire clrB = mopPop & (mopq_reg[rdPtr_reg].regIdx == REG_IDX_W'(gi));
            always_ff @(posedge sys_clk) begin
                if (sys_rst || resetReq) begin
                    busy_reg[gi] <= 1'b0;
                end else if (setB) begin
                    busy_reg[gi] <= 1'b1; // RULE12
                end else if (clrB) begin
                    busy_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // a register may have several ops queued; the bit clears on the first,
    // so the issuer must not queue a second op on a busy register
    assign elemStall = busy_reg[useRegA] | busy_reg[useRegB]; // RULE12

    // ************************************************************
    // status, mask and request words
    // ************************************************************
    logic [MEM_ERR_BITS-1:0] memStatus_reg;
    logic [MASK_SRCS-1:0]    mask_reg;
    logic [MASK_SRCS-1:0]    treq_reg;
    logic                    step_reg;
    logic                    ien_reg;
    logic                    haltSeen_reg;
    logic [WORD_W-1:0]       csrRdata_reg;

    wire memErr   = mopPop & (|memRespErr);
    wire csrWr    = csrReq.valid & csrReq.write & csrReq.supervisor;
    wire newEvent = vmeCtrlWr | memErr;
    // while halted only the maskable requests from the first cycle with a new event are kept
    wire evAllowed = ~halted | ~haltSeen_reg; // RULE20

    wire [MASK_SRCS-1:0] evBits = {memErr, 4'(vmeCtrlWr) << vmeSet};
    wire [MASK_SRCS-1:0] liveReq = treq_reg & ~mask_reg;

    // ************************************************************
    // priority selection
    // ************************************************************
    logic [2:0] maskIdx;
    always_comb begin
        maskIdx = 3'h0;
        for (int i = MASK_SRCS - 1; i >= 0; i--) begin
            if (liveReq[i]) begin
                maskIdx = 3'(i);
            end
        end
    end

    wire maskAny = (|liveReq) & ien_reg; // RULE15 RULE10

    always_comb begin
        trapValid     = 1'b1;
        trapSource    = 3'h0;
        trapPrecise   = 1'b1;
        trapResumable = 1'b1;
        if (resetReq) begin
            trapCause     = TPU_CAUSE_RESET; // RULE17 RULE18
            trapPrecise   = 1'b0;
            trapResumable = 1'b0;
        end else if (faultReq) begin
            trapCause     = TPU_CAUSE_FAULT; // RULE17
            trapPrecise   = 1'b0;
            trapResumable = 1'b0;
        end else if (callReq) begin
            trapCause     = TPU_CAUSE_CALL; // RULE17
        end else if (breakReq) begin
            trapCause     = TPU_CAUSE_BREAK; // RULE2
        end else if (stepReq & step_reg) begin
            trapCause     = TPU_CAUSE_STEP; // RULE2
        end else if (maskAny & ~halted) begin
            trapCause     = TPU_CAUSE_MASK;
            trapSource    = maskIdx;
            // memory-operation traps complete out of instruction flow
            trapPrecise   = (maskIdx != 3'(MEM_SRC_IDX)); // RULE13 RULE10
            trapResumable = trapPrecise;
        end else begin
            trapValid     = 1'b0;
            trapCause     = TPU_CAUSE_MASK;
        end
    end

    wire takeMask  = trapAccept & trapValid & (trapCause == TPU_CAUSE_MASK);
    wire takeReset = trapAccept & trapValid & (trapCause == TPU_CAUSE_RESET);
    wire [MASK_SRCS-1:0] clrBits = takeReset ? MASK_RESET
                                 : (takeMask ? (5'h01 << maskIdx) : 5'h00);
    wire [MASK_SRCS-1:0] setBits = (evAllowed & ~takeReset) ? evBits : 5'h00;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            treq_reg <= '0;
        end else begin
            // set beats a same-cycle clear of the same bit
            treq_reg <= (treq_reg & ~clrBits) | setBits; // RULE7 RULE21
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            haltSeen_reg <= 1'b0;
        end else begin
            haltSeen_reg <= halted & (haltSeen_reg | newEvent); // RULE20
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            memStatus_reg <= '0;
        end else if (memErr) begin
            memStatus_reg <= memStatus_reg | memRespErr; // RULE14
        end else if (csrWr && csrReq.sel == CSR_SEL_MSTS) begin
            memStatus_reg <= csrReq.wdata[MEM_ERR_BITS-1:0]; // RULE16
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask_reg <= MASK_RESET;
        end else if (csrWr && csrReq.sel == CSR_SEL_MASK) begin
            mask_reg <= csrReq.wdata[MASK_SRCS-1:0];
        end
    end

    // the handler runs with stepping and maskable traps off
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            step_reg <= 1'b0;
            ien_reg  <= 1'b0;
        end else if (trapAccept && trapValid) begin
            step_reg <= 1'b0; // RULE1 RULE19
            ien_reg  <= 1'b0; // RULE19
        end else if (pswRestore) begin
            step_reg <= pswRestoreVal[PSW_STEP_BIT];
            ien_reg  <= pswRestoreVal[PSW_IEN_BIT];
        end else if (csrWr && csrReq.sel == CSR_SEL_PSW) begin
            step_reg <= csrReq.wdata[PSW_STEP_BIT];
            ien_reg  <= csrReq.wdata[PSW_IEN_BIT];
        end
    end

    assign stepEnable = step_reg;
    assign intEnable  = ien_reg;

    wire [WORD_W-1:0] csrMux =
        (csrReq.sel == CSR_SEL_PSW)  ? {30'h0, ien_reg, step_reg} :
        (csrReq.sel == CSR_SEL_MASK) ? {27'h0, mask_reg} :
        (csrReq.sel == CSR_SEL_MSTS) ? {30'h0, memStatus_reg} :
                                       {27'h0, treq_reg};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            csrRdata_reg <= '0;
        end else if (csrReq.valid) begin
            csrRdata_reg <= csrMux;
        end
    end

    assign csrRdata = csrRdata_reg;

    // memory trap request follows error arrival, status stays
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    AST_STEP_CLR_ON_ENTRY: assert property ( // RULE1
        trapAccept && trapValid |=> !stepEnable && !intEnable)
        else $error("step or enable not cleared on trap entry");
    AST_BREAK_UNMASKED: assert property ( // RULE2
        breakReq && !resetReq && !faultReq && !callReq
        |-> trapValid && trapCause == TPU_CAUSE_BREAK && trapResumable)
        else $error("breakpoint trap not raised");
    AST_MBOX_READBACK: assert property ( // RULE5
        vmeWr && !smemWr ##1 !vmeWr && !smemWr ##1 smemReq.valid && !smemReq.write
        && smemReq.addr == $past(vmeReq.addr, 2) && !vmeWr && !smemWr
        |=> smemRdata == $past(vmeReq.wdata, 3))
        else $error("mailbox read did not return written word");
    AST_CTRL_SETS_REQ: assert property ( // RULE7
        vmeCtrlWr && !halted && !takeReset
        |=> treq_reg[$past(vmeSet)])
        else $error("control word write did not request trap");
    AST_SMEM_NO_TRAP: assert property ( // RULE8
        !vmeCtrlWr && !memErr |=> (treq_reg & ~$past(treq_reg)) == '0)
        else $error("request bit set without cause");
    AST_MEM_IMPRECISE: assert property ( // RULE13
        trapValid && trapCause == TPU_CAUSE_MASK
        && trapSource == 3'(MEM_SRC_IDX) |-> !trapPrecise)
        else $error("memory trap reported precise");
    AST_MEM_STATUS_SET: assert property ( // RULE14
        memErr |=> (memStatus_reg & $past(memRespErr)) == $past(memRespErr))
        else $error("memory error not recorded");
    AST_MASK_GATED: assert property ( // RULE15
        trapValid && trapCause == TPU_CAUSE_MASK |-> intEnable
        && !mask_reg[trapSource])
        else $error("maskable trap while disabled or masked");
    AST_STATUS_STICKY: assert property ( // RULE16
        !(csrWr && csrReq.sel == CSR_SEL_MSTS) |=>
        (memStatus_reg & $past(memStatus_reg)) == $past(memStatus_reg))
        else $error("status cleared without supervisor move");
    AST_RESET_FIRST: assert property ( // RULE18
        resetReq |-> trapValid && trapCause == TPU_CAUSE_RESET)
        else $error("reset did not override");
    AST_REQ_PENDS: assert property ( // RULE21
        treq_reg[0] && !(takeMask && maskIdx == 3'h0) && !takeReset
        |=> treq_reg[0])
        else $error("request dropped before trap taken");
    AST_FIFO_ORDER: assert property ( // RULE11
        memReqValid && !memReqReady && !resetReq |=> $stable(memReq))
        else $error("head changed while waiting");

endmodule : tpu_trap_unit

// [test/tb_trap_request_priority_unit.sv]
`timescale 1ns/1ps

module tb_trap_request_priority_unit
    import tpu_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    int   errTotal = 0;
    int   totalChecks = 0;
    int   cyc = 0;
    tpu_mbox_req_t vmeReq, smemReq;
    tpu_csr_req_t  csrReq;
    tpu_cause_t    trapCause;
    tpu_mop_t      mopIn, memReq;
    logic [31:0]   vmeRdata, smemRdata, csrRdata;
    logic [5:0]    useRegA, useRegB;
    logic [2:0]    trapSource;
    logic [1:0]    pswRestoreVal, memRespErr;
    logic vmeAck, smemAck, resetReq, faultReq, callReq, breakReq, stepReq, halted;
    logic pswRestore, trapValid, trapPrecise, trapResumable, trapAccept;
    logic stepEnable, intEnable, mopValid, mopBoundsDone, mopReady, elemStall;
    logic memReqValid, memReqReady, memRespValid;
    logic [31:0]   mbox [32];
    logic [4:0]    treqM;
    logic [1:0]    mstsM;
    tpu_mop_t      mq [$];

    always #5 sys_clk = ~sys_clk;

    tpu_trap_unit #(.MOP_DEPTH(4), .MOP_PTR_W(2)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .vmeReq(vmeReq), .vmeAck(vmeAck),
        .vmeRdata(vmeRdata), .smemReq(smemReq), .smemAck(smemAck), .smemRdata(smemRdata),
        .csrReq(csrReq), .csrRdata(csrRdata), .resetReq(resetReq), .faultReq(faultReq),
        .callReq(callReq), .breakReq(breakReq), .stepReq(stepReq), .halted(halted),
        .pswRestore(pswRestore), .pswRestoreVal(pswRestoreVal), .trapValid(trapValid),
        .trapCause(trapCause), .trapSource(trapSource), .trapPrecise(trapPrecise),
        .trapResumable(trapResumable), .trapAccept(trapAccept), .stepEnable(stepEnable),
        .intEnable(intEnable), .mopValid(mopValid), .mopBoundsDone(mopBoundsDone),
        .mopIn(mopIn), .mopReady(mopReady), .useRegA(useRegA), .useRegB(useRegB),
        .elemStall(elemStall), .memReqValid(memReqValid), .memReq(memReq),
        .memReqReady(memReqReady), .memRespValid(memRespValid), .memRespErr(memRespErr)
    );

    tpu_vme_master vme (.sys_clk(sys_clk), .vmeReq(vmeReq), .vmeAck(vmeAck),
                        .vmeRdata(vmeRdata));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic chkW(input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e) begin
            errTotal++;
            $display("unexpected at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chkW

    // valid, cause, source, precise
    task automatic chkT(input logic [7:0] e);
        chkW({24'h0, e}, {24'h0, trapValid, trapCause, trapSource, trapPrecise});
    endtask : chkT

    task automatic smemAcc(input logic wr, input logic [4:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        tick;
        smemReq <= '{1'b1, wr, a, d};
        tick;
        chkW(32'h1, {31'h0, smemAck});
        q = smemRdata;
        smemReq <= '{1'b0, ~wr, ~a, ~d};
    endtask : smemAcc

    task automatic mbAcc(input bit bus, input logic wr, input logic [4:0] a,
                         input logic [31:0] d, output logic [31:0] q);
        logic ok;
        if (bus) begin
            vme.access(wr, a, d, q, ok);
            chkW(32'h1, {31'h0, ok});
        end else begin
            smemAcc(wr, a, d, q);
        end
        if (wr) mbox[a] = d;
    endtask : mbAcc

    task automatic csrAcc(input logic wr, input logic sup, input logic [1:0] sel,
                          input logic [31:0] d, output logic [31:0] q);
        tick;
        csrReq <= '{1'b1, wr, sup, sel, d};
        tick;
        q = csrRdata;
        csrReq <= '{1'b0, 1'b0, 1'b0, ~sel, ~d};
    endtask : csrAcc

    task automatic accept;
        trapAccept <= 1'b1;
        tick;
        trapAccept <= 1'b0;
    endtask : accept

    task automatic conclude;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errTotal++;
            conclude;
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        logic [31:0] q, d;
        logic [4:0]  a;
        bit          side;
        tpu_mop_t    op;
        smemReq = '0;
        csrReq = '0;
        {resetReq, faultReq, callReq, breakReq, stepReq, halted, pswRestore} = '0;
        {trapAccept, mopValid, mopBoundsDone, memReqReady, memRespValid} = '0;
        {pswRestoreVal, memRespErr, useRegA, useRegB, mopIn} = '0;
        foreach (mbox[i]) mbox[i] = 32'h0;
        treqM = 5'h0;
        mstsM = 2'h0;
        void'($urandom(32'h6620));
        repeat (2) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        for (int s = 0; s < 4; s++) begin
            csrAcc(1'b0, 1'b1, 2'(s), 32'h0, q);
            chkW((s == 1) ? {27'h0, MASK_RESET} : 32'h0, q);
        end
        $display("test reset values done");

        repeat (24) begin
            a = 5'($urandom_range(31));
            if (a[2:0] == 3'h0) a[2:0] = 3'h1;
            d = $urandom;
            side = 1'($urandom_range(1));
            mbAcc(side, 1'b1, a, d, q);
            mbAcc(!side, 1'b0, a, 32'h0, q);
            chkW(mbox[a], q);
        end
        for (int s = 0; s < 4; s++) begin
            d = $urandom | 32'h1;
            vme.request(2'(s), d);
            mbox[{2'(s), 3'h0}] = d;
            treqM[s] = 1'b1;
        end
        mbAcc(1'b0, 1'b1, 5'h08, 32'h5a, q);
        mbAcc(1'b1, 1'b0, 5'h08, 32'h0, q);
        chkW(32'h5a, q);
        csrAcc(1'b0, 1'b1, CSR_SEL_TREQ, 32'h0, q);
        chkW({27'h0, treqM}, q);
        $display("test mailbox done");

        csrAcc(1'b1, 1'b1, CSR_SEL_PSW, 32'h2, q);
        chkW(32'h0, {31'h0, trapValid});
        csrAcc(1'b1, 1'b0, CSR_SEL_MASK, 32'h0, q);
        csrAcc(1'b0, 1'b1, CSR_SEL_MASK, 32'h0, q);
        chkW({27'h0, MASK_RESET}, q);
        csrAcc(1'b1, 1'b1, CSR_SEL_MASK, 32'h0, q);
        for (int s = 0; s < 4; s++) begin
            chkT({1'b1, TPU_CAUSE_MASK, 3'(s), 1'b1});
            chkW(32'h1, {31'h0, trapResumable});
            accept;
            treqM[s] = 1'b0;
            chkW(32'h0, {30'h0, intEnable, stepEnable});
            mbAcc(1'b0, 1'b1, {2'(s), 3'h0}, 32'h0, q);
            csrAcc(1'b1, 1'b1, CSR_SEL_PSW, 32'h2, q);
        end
        chkW(32'h0, {31'h0, trapValid});
        $display("test mailbox traps done");

        vme.request(2'h1, 32'h7);
        treqM[1] = 1'b1;
        pswRestoreVal <= 2'b01;
        pswRestore <= 1'b1;
        tick;
        pswRestore <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            {stepReq, breakReq, callReq, faultReq, resetReq} <= 5'h1f << k;
            tick;
            chkW({28'h0, 1'b1, 3'(k)}, {28'h0, trapValid, trapCause});
            if (k == 0) chkW(32'h0, {31'h0, mopReady});
            if (k > 2) chkW(32'h1, {31'h0, trapResumable});
        end
        accept;
        stepReq <= 1'b0;
        tick;
        chkW(32'h0, {30'h0, stepEnable, trapValid});
        csrAcc(1'b1, 1'b1, CSR_SEL_PSW, 32'h2, q);
        chkT({1'b1, TPU_CAUSE_MASK, 3'h1, 1'b1});
        accept;
        treqM[1] = 1'b0;
        mbAcc(1'b0, 1'b1, 5'h08, 32'h0, q);
        $display("test priority done");

        csrAcc(1'b1, 1'b1, CSR_SEL_PSW, 32'h2, q);
        mopValid <= 1'b1;
        mopIn <= '{1'b1, 6'h3f, 16'h0};
        tick;
        for (int i = 0; i < 2; i++) begin
            chkW(32'h1, {31'h0, mopReady});
            op = '{1'(i), 6'(3 + i), 16'($urandom)};
            mopIn <= op;
            mopBoundsDone <= 1'b1;
            mq.push_back(op);
            tick;
        end
        {mopValid, mopBoundsDone} <= 2'b00;
        useRegA <= 6'h3;
        useRegB <= 6'h20;
        tick;
        chkW(32'h1, {31'h0, elemStall});
        while (mq.size() > 0) begin
            chkW({8'h0, 1'b1, mq[0]}, {8'h0, memReqValid, memReq});
            memReqReady <= 1'b1;
            tick;
            memReqReady <= 1'b0;
            repeat (2) tick;
            memRespValid <= 1'b1;
            memRespErr <= 2'(3 - mq.size());
            {treqM[4], mstsM} = {1'b1, mstsM | 2'(3 - mq.size())};
            tick;
            {memRespValid, memRespErr} <= 3'b000;
            void'(mq.pop_front());
        end
        tick;
        chkW(32'h0, {31'h0, elemStall});
        chkT({1'b1, TPU_CAUSE_MASK, 3'h4, 1'b0});
        csrAcc(1'b1, 1'b0, CSR_SEL_MSTS, 32'h0, q);
        csrAcc(1'b0, 1'b1, CSR_SEL_MSTS, 32'h0, q);
        chkW({30'h0, mstsM}, q);
        csrAcc(1'b1, 1'b1, CSR_SEL_MSTS, 32'h0, q);
        mstsM = 2'h0;
        csrAcc(1'b0, 1'b1, CSR_SEL_MSTS, 32'h0, q);
        chkW({30'h0, mstsM}, q);
        accept;
        treqM[4] = 1'b0;
        $display("test memory queue done");

        csrAcc(1'b1, 1'b1, CSR_SEL_PSW, 32'h2, q);
        halted <= 1'b1;
        vme.request(2'h2, 32'h3);
        vme.request(2'h0, 32'h3);
        treqM[2] = 1'b1;
        csrAcc(1'b0, 1'b1, CSR_SEL_TREQ, 32'h0, q);
        chkW({27'h0, treqM}, q);
        chkW(32'h0, {31'h0, trapValid});
        halted <= 1'b0;
        tick;
        chkT({1'b1, TPU_CAUSE_MASK, 3'h2, 1'b1});
        $display("test halt done");
        conclude;
    end
endmodule : tb_trap_request_priority_unit

// [test/tpu_vme_master.sv]
`timescale 1ns/1ps

module tpu_vme_master
    import tpu_pkg::*;
(
    input  wire logic        sys_clk,
    output tpu_mbox_req_t    vmeReq,
    input  wire logic        vmeAck,
    input  wire logic [31:0] vmeRdata
);
    // ************************************************************
    // bus master cycles
    // ************************************************************
    initial vmeReq = '0;

    // one-cycle strobe; the answer is taken once the next edge has landed
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        @(posedge sys_clk);
        #1;
        vmeReq <= '{1'b1, wr, a, d};
        @(posedge sys_clk);
        #1;
        ok = vmeAck;
        q = vmeRdata;
        // released lines must not keep showing the last value
        vmeReq <= '{1'b0, ~wr, ~a, ~d};
    endtask : access

    // slow poller: raise a new request only after a zero acknowledge
    task automatic request(input logic [1:0] s, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        q = 32'h1;
        for (int i = 0; i < 8 && q !== 32'h0; i++) begin
            access(1'b0, {s, 3'h0}, 32'h0, q, ok);
        end
        if (q === 32'h0) access(1'b1, {s, 3'h0}, d, q, ok);
    endtask : request
endmodule : tpu_vme_master
